// *** hw/adc_port_pkg.sv ***
// constants, types and helpers shared by both ends of the converter serial port
// assumes one 25 MHz ref_clk for both ends; ref_clk also stands in for the master clock
package adc_port_pkg;
  localparam int WORD_W = 16;
  localparam int FRAME_W = 22;
  localparam int PACKET_W = 11;
  localparam int BITS_W = 5;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = WORD_W + 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SELF_SCLK_PERIOD_NS = 320;
  localparam int SELF_HALF_CYC = SELF_SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int LEAD_NS = 250;
  localparam int LEAD_CYC = (LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UPDATE_CYC = 4;
  localparam int CS_PROP_MCLK = 4;
  localparam int CS_PROP_NS = 160;
  localparam int CS_SETUP_CYC = CS_PROP_MCLK + (CS_PROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_SCLK_PERIOD_NS = 640;
  localparam int HOST_HALF_CYC = HOST_SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int TRIM_SETUP_NS = 100;
  localparam int TRIM_CYC = (TRIM_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] CODE_FULL = 16'hffff;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [7:0] DEV_SYNC_INIT = 8'h0d;
  localparam logic [2:0] HOST_SYNC_INIT = 3'h3;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SLEEP_BIT = 2;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_CAL_BIT = 1;
  localparam int CMD_TRIM_LSB = 2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_VALID_BIT = 1;
  localparam int ST_READY_BIT = 2;
  localparam int ST_CAL_BIT = 3;
  typedef logic [3:0] cnt_t;
  typedef logic [BITS_W-1:0] bits_t;
  typedef enum logic [1:0] {
    MODE_HOST = 2'b00,
    MODE_SELF = 2'b01,
    MODE_ASYNC = 2'b10
  } mode_t;

  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) begin
      r[k] = b[7-k];
    end
    return r;
  endfunction
endpackage

// *** hw/adc_link_if.sv ***
// pins between the converter port and its host controller
// wire levels are resolved here; an undriven data line idles high, an undriven clock low
`timescale 1ns/100ps
interface adc_link_if;
  logic cs_n;
  logic sleep_n;
  logic cal_request_n;
  logic trim_select_0;
  logic trim_select_1;
  logic [1:0] mode_strap;
  logic word_ready_n;
  logic serial_out_line;
  logic serial_out_oe;
  logic sclk_dev;
  logic sclk_dev_oe;
  logic sclk_host;
  logic sclk_host_oe;
  logic serial_out_line_wire;
  logic sclk_wire;

  assign serial_out_line_wire = serial_out_oe ? serial_out_line : 1'b1;
  // device drive wins if both ends ever drive the clock at once
  assign sclk_wire = sclk_dev_oe ? sclk_dev : (sclk_host_oe ? sclk_host : 1'b0);

  modport device (
    input cs_n, sleep_n, cal_request_n, trim_select_0, trim_select_1, mode_strap, sclk_wire,
    output word_ready_n, serial_out_line, serial_out_oe, sclk_dev, sclk_dev_oe
  );
  modport host (
    output cs_n, sleep_n, cal_request_n, trim_select_0, trim_select_1, mode_strap,
    output sclk_host, sclk_host_oe,
    input word_ready_n, serial_out_line_wire, sclk_wire
  );
endinterface // adc_link_if

// *** hw/word_fifo.sv ***
// synchronous fifo with valid/ready on both sides
// assumes one clock; ready and valid are registered
`timescale 1ns/100ps
module word_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic [PW:0] count_nxt;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      if (push) begin
        wr_ptr_r <= PW'(wr_ptr_r + 1'b1);
      end
      if (pop) begin
        rd_ptr_r <= PW'(rd_ptr_r + 1'b1);
      end
      count_r <= count_nxt;
      in_ready <= count_nxt != (PW+1)'(DEPTH);
      out_valid <= count_nxt != '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule // word_fifo

// *** hw/adc_port_device.sv ***
// converter end of the serial output port: word buffer, clamp, three shift modes
// assumes all link inputs are asynchronous; ref_clk acts as the master clock
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
module adc_port_device (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [adc_port_pkg::WORD_W-1:0] sample_word,
  input wire logic sample_above_ref,
  input wire logic sample_below_floor,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic cal_start,
  output logic [1:0] cal_select,
  output adc_port_pkg::mode_t port_mode,
  adc_link_if.device link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_UPDATE = 3'b001,
    ST_LEAD = 3'b010,
    ST_HI = 3'b011,
    ST_LO = 3'b100,
    ST_EXT = 3'b101
  } dev_state_t;

  localparam int NS = 8;
  logic [NS-1:0] raw;
  logic [NS-1:0] q_w;
  logic [NS-1:0] q_d_r;
  dev_state_t state_r;
  logic [adc_port_pkg::FRAME_W-1:0] frame_r;
  logic [adc_port_pkg::FRAME_W-1:0] frame_w;
  adc_port_pkg::bits_t bits_r;
  adc_port_pkg::cnt_t cnt_r;
  logic [adc_port_pkg::WORD_W-1:0] word_r;
  logic [adc_port_pkg::WORD_W-1:0] clamp_w;
  logic have_r;
  logic ready_n_r;
  logic dout_r;
  logic doe_r;
  logic sclk_r;
  logic sclk_oe_r;
  logic stop_r;
  logic cal_start_r;
  logic [1:0] cal_sel_r;
  adc_port_pkg::mode_t mode_r;
  logic fifo_valid;
  logic [adc_port_pkg::FIFO_W-1:0] fifo_data;
  logic pop;
  logic cs_low;
  logic asleep;
  logic sclk_fall;
  logic cal_fall;
  logic start_go;
  logic stop_now;
  logic done_ext;
  logic end_now;
  logic shift_now;

  assign raw = {link.mode_strap, link.trim_select_1, link.trim_select_0,
                link.cal_request_n, link.sleep_n, link.sclk_wire, link.cs_n};

  // three stages; a change is taken only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < NS; i++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic q;
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          s1 <= adc_port_pkg::DEV_SYNC_INIT[i];
          s2 <= adc_port_pkg::DEV_SYNC_INIT[i];
          s3 <= adc_port_pkg::DEV_SYNC_INIT[i];
          q <= adc_port_pkg::DEV_SYNC_INIT[i];
        end else if (clk_en) begin
          s1 <= raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign q_w[i] = q;
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_d_r <= adc_port_pkg::DEV_SYNC_INIT;
    end else if (clk_en) begin
      q_d_r <= q_w;
    end
  end

  assign cs_low = !q_w[0];
  assign sclk_fall = q_d_r[1] && !q_w[1];
  assign asleep = !q_w[2];
  assign cal_fall = q_d_r[3] && !q_w[3];

  word_fifo #(
    .WIDTH(adc_port_pkg::FIFO_W),
    .DEPTH(adc_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_above_ref, sample_below_floor, sample_word}),
    .out_valid(fifo_valid),
    .out_ready(pop),
    .out_data(fifo_data)
  );

  // overrange wins if both flags are ever set together
  assign clamp_w = fifo_data[adc_port_pkg::WORD_W+1] ? adc_port_pkg::CODE_FULL :
                   fifo_data[adc_port_pkg::WORD_W] ? adc_port_pkg::CODE_ZERO :
                   fifo_data[adc_port_pkg::WORD_W-1:0];

  // async frame: two 11-bit packets, start 0, byte lsb first, two stop 1s
  assign frame_w = (mode_r == adc_port_pkg::MODE_ASYNC) ?
      {1'b0, adc_port_pkg::rev8(word_r[15:8]), 2'b11,
       1'b0, adc_port_pkg::rev8(word_r[7:0]), 2'b11} :
      {word_r, 6'h00};

  // a transfer starts only from idle, so select during the update window is not seen
  assign start_go = have_r && !ready_n_r && cs_low && !asleep;
  assign pop = (state_r == ST_IDLE) && fifo_valid && !start_go && !asleep;
  assign stop_now = stop_r || !cs_low;
  assign done_ext = (bits_r == adc_port_pkg::bits_t'(1)) ||
      (stop_now && ((mode_r != adc_port_pkg::MODE_ASYNC) ||
                    (bits_r == adc_port_pkg::bits_t'(adc_port_pkg::PACKET_W + 1))));

  always_comb begin
    end_now = 1'b0;
    shift_now = 1'b0;
    case (state_r)
      ST_LO: begin
        if (cnt_r == adc_port_pkg::cnt_t'(adc_port_pkg::SELF_HALF_CYC - 1)) begin
          if (bits_r == adc_port_pkg::bits_t'(1) || stop_now) begin
            end_now = 1'b1;
          end else begin
            shift_now = 1'b1;
          end
        end
      end
      ST_EXT: begin
        if (sclk_fall) begin
          end_now = done_ext;
          shift_now = !done_ext;
        end
      end
      default: begin
        end_now = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      frame_r <= '0;
      bits_r <= '0;
      cnt_r <= '0;
      word_r <= '0;
      have_r <= 1'b0;
      ready_n_r <= 1'b1;
      dout_r <= 1'b1;
      doe_r <= 1'b0;
      sclk_r <= 1'b0;
      sclk_oe_r <= 1'b0;
      stop_r <= 1'b0;
    end else if (clk_en) begin
      if (!cs_low && state_r != ST_IDLE && state_r != ST_UPDATE) begin
        stop_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          doe_r <= 1'b0;
          sclk_oe_r <= 1'b0;
          stop_r <= 1'b0;
          if (asleep) begin
            ready_n_r <= 1'b1;
            have_r <= 1'b0;
          end else if (start_go) begin
            frame_r <= frame_w;
            dout_r <= frame_w[adc_port_pkg::FRAME_W-1];
            doe_r <= 1'b1;
            bits_r <= (mode_r == adc_port_pkg::MODE_ASYNC) ?
                adc_port_pkg::bits_t'(adc_port_pkg::FRAME_W) :
                adc_port_pkg::bits_t'(adc_port_pkg::WORD_W);
            if (mode_r == adc_port_pkg::MODE_SELF) begin
              sclk_oe_r <= 1'b1;
              sclk_r <= 1'b0;
              cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::LEAD_CYC - 1);
              state_r <= ST_LEAD;
            end else begin
              state_r <= ST_EXT;
            end
          end else if (fifo_valid) begin
            word_r <= clamp_w;
            ready_n_r <= 1'b1;
            cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::UPDATE_CYC - 1);
            state_r <= ST_UPDATE;
          end
        end
        ST_UPDATE: begin
          if (cnt_r == '0) begin
            ready_n_r <= 1'b0;
            have_r <= 1'b1;
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        ST_LEAD, ST_HI, ST_LO: begin
          if (cnt_r == '0) begin
            sclk_r <= (state_r != ST_HI);
            cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::SELF_HALF_CYC - 1);
            state_r <= (state_r == ST_HI) ? ST_LO : ST_HI;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
      if (shift_now) begin
        frame_r <= frame_r << 1;
        dout_r <= frame_r[adc_port_pkg::FRAME_W-2];
        bits_r <= bits_r - 1'b1;
      end
      if (end_now) begin
        doe_r <= 1'b0;
        sclk_oe_r <= 1'b0;
        sclk_r <= 1'b0;
        have_r <= 1'b0;
        ready_n_r <= 1'b1;
        state_r <= ST_IDLE;
      end
    end
  end

  // strap is static; re-reading it only between transfers avoids a mid-word switch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r <= adc_port_pkg::MODE_HOST;
    end else if (clk_en && state_r == ST_IDLE) begin
      mode_r <= (q_w[7:6] == 2'b11) ? adc_port_pkg::MODE_HOST :
                adc_port_pkg::mode_t'(q_w[7:6]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_start_r <= 1'b0;
      cal_sel_r <= 2'b00;
    end else if (clk_en) begin
      cal_start_r <= cal_fall;
      if (cal_fall) begin
        cal_sel_r <= q_w[5:4];
      end
    end
  end

  assign cal_start = cal_start_r;
  assign cal_select = cal_sel_r;
  assign port_mode = mode_r;
  assign link.word_ready_n = ready_n_r;
  assign link.serial_out_line = dout_r;
  assign link.serial_out_oe = doe_r;
  assign link.sclk_dev = sclk_r;
  assign link.sclk_dev_oe = sclk_oe_r;
endmodule // adc_port_device

// *** hw/adc_port_host.sv ***
// host controller end: apb registers, select, shift clock, calibration and sleep pins
// assumes the device end on the same link; all link inputs treated as asynchronous
`timescale 1ns/100ps
module adc_port_host (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adc_link_if.host link
);
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_WAIT = 3'b001,
    H_SETUP = 3'b010,
    H_HI = 3'b011,
    H_LO = 3'b100,
    H_RX = 3'b101
  } host_state_t;

  logic [2:0] raw;
  logic [2:0] q_w;
  logic [2:0] q_d_r;
  host_state_t state_r;
  adc_port_pkg::cnt_t cnt_r;
  adc_port_pkg::bits_t bits_r;
  logic [adc_port_pkg::FRAME_W-1:0] rx_r;
  logic [adc_port_pkg::FRAME_W-1:0] rx_nxt;
  logic [adc_port_pkg::WORD_W-1:0] data_r;
  logic valid_r;
  logic [1:0] mode_r;
  logic sleep_r;
  logic cs_n_r;
  logic sclk_r;
  logic sclk_oe_r;
  logic cal_busy_r;
  logic cal_n_r;
  adc_port_pkg::cnt_t cal_cnt_r;
  logic [1:0] trim_r;
  logic wr_en;
  logic rd_data;
  logic start_cmd;
  logic done;
  logic rx_take;

  assign raw = {link.sclk_wire, link.serial_out_line_wire, link.word_ready_n};

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_sync
      logic s1;
      logic s2;
      logic s3;
      logic q;
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          s1 <= adc_port_pkg::HOST_SYNC_INIT[i];
          s2 <= adc_port_pkg::HOST_SYNC_INIT[i];
          s3 <= adc_port_pkg::HOST_SYNC_INIT[i];
          q <= adc_port_pkg::HOST_SYNC_INIT[i];
        end else if (clk_en) begin
          s1 <= raw[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign q_w[i] = q;
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_d_r <= adc_port_pkg::HOST_SYNC_INIT;
    end else if (clk_en) begin
      q_d_r <= q_w;
    end
  end

  // zero wait states: pready is registered from the setup cycle and is high in the first access cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && paddr != adc_port_pkg::REG_CTRL &&
                 paddr != adc_port_pkg::REG_CMD && paddr != adc_port_pkg::REG_STATUS &&
                 paddr != adc_port_pkg::REG_DATA;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          adc_port_pkg::REG_CTRL: prdata <= {29'h0, sleep_r, mode_r};
          adc_port_pkg::REG_STATUS: prdata <= {28'h0, cal_busy_r, !q_w[0], valid_r,
                                               state_r != H_IDLE};
          adc_port_pkg::REG_DATA: prdata <= {16'h0, data_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_data = psel && penable && pready && !pwrite && paddr == adc_port_pkg::REG_DATA;
  assign start_cmd = wr_en && paddr == adc_port_pkg::REG_CMD &&
                     pwdata[adc_port_pkg::CMD_START_BIT] && state_r == H_IDLE && !sleep_r;
  assign rx_nxt = {rx_r[adc_port_pkg::FRAME_W-2:0], q_w[1]};
  assign rx_take = (state_r == H_HI && cnt_r == '0) ||
                   (state_r == H_RX && !q_d_r[2] && q_w[2]);
  assign done = rx_take && bits_r == adc_port_pkg::bits_t'(1);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_r <= adc_port_pkg::MODE_HOST;
      sleep_r <= 1'b0;
    end else if (clk_en && wr_en && paddr == adc_port_pkg::REG_CTRL) begin
      mode_r <= pwdata[adc_port_pkg::CTRL_MODE_LSB +: 2];
      sleep_r <= pwdata[adc_port_pkg::CTRL_SLEEP_BIT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      bits_r <= '0;
      rx_r <= '0;
      data_r <= '0;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      sclk_oe_r <= 1'b0;
    end else if (clk_en) begin
      if (rx_take) begin
        rx_r <= rx_nxt;
        bits_r <= bits_r - 1'b1;
      end
      case (state_r)
        H_IDLE: begin
          if (start_cmd) begin
            state_r <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (!q_w[0]) begin
            cs_n_r <= 1'b0;
            sclk_oe_r <= mode_r != adc_port_pkg::MODE_SELF;
            cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::CS_SETUP_CYC - 1);
            bits_r <= (mode_r == adc_port_pkg::MODE_ASYNC) ?
                adc_port_pkg::bits_t'(adc_port_pkg::FRAME_W) :
                adc_port_pkg::bits_t'(adc_port_pkg::WORD_W);
            state_r <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (mode_r == adc_port_pkg::MODE_SELF) begin
            state_r <= H_RX;
          end else begin
            sclk_r <= 1'b1;
            cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::HOST_HALF_CYC - 1);
            state_r <= H_HI;
          end
        end
        H_HI, H_LO: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            sclk_r <= state_r == H_LO;
            cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::HOST_HALF_CYC - 1);
            state_r <= (state_r == H_HI) ? H_LO : H_HI;
          end
        end
        default: begin
          state_r <= state_r;
        end
      endcase
      if (done) begin
        cs_n_r <= 1'b1;
        sclk_r <= 1'b0;
        sclk_oe_r <= 1'b0;
        state_r <= H_IDLE;
        data_r <= (mode_r == adc_port_pkg::MODE_ASYNC) ?
            {adc_port_pkg::rev8(rx_nxt[20:13]), adc_port_pkg::rev8(rx_nxt[9:2])} :
            rx_nxt[adc_port_pkg::WORD_W-1:0];
      end
    end
  end

  // a word completing in the same cycle as a data read stays flagged
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      valid_r <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        valid_r <= 1'b1;
      end else if (rd_data) begin
        valid_r <= 1'b0;
      end
    end
  end

  // trims change only here and stay put after the request edge, covering hold time
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cal_busy_r <= 1'b0;
      cal_n_r <= 1'b1;
      cal_cnt_r <= '0;
      trim_r <= 2'b00;
    end else if (clk_en) begin
      if (!cal_busy_r) begin
        if (wr_en && paddr == adc_port_pkg::REG_CMD && pwdata[adc_port_pkg::CMD_CAL_BIT]) begin
          trim_r <= pwdata[adc_port_pkg::CMD_TRIM_LSB +: 2];
          cal_cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::TRIM_CYC - 1);
          cal_busy_r <= 1'b1;
        end
      end else if (cal_cnt_r != '0) begin
        cal_cnt_r <= cal_cnt_r - 1'b1;
      end else if (cal_n_r) begin
        cal_n_r <= 1'b0;
        cal_cnt_r <= adc_port_pkg::cnt_t'(adc_port_pkg::TRIM_CYC - 1);
      end else begin
        cal_n_r <= 1'b1;
        cal_busy_r <= 1'b0;
      end
    end
  end

  assign link.cs_n = cs_n_r;
  assign link.sleep_n = !sleep_r;
  assign link.cal_request_n = cal_n_r;
  assign link.trim_select_0 = trim_r[0];
  assign link.trim_select_1 = trim_r[1];
  assign link.mode_strap = mode_r;
  assign link.sclk_host = sclk_r;
  assign link.sclk_host_oe = sclk_oe_r;
endmodule // adc_port_host

// *** testbench/adc_link_checker.sv ***
// link wire assertions for the converter serial port
// assumes the link interface wires and a single ref_clk domain
`timescale 1ns/100ps
module adc_link_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic [1:0] mode_strap,
  input wire logic word_ready_n,
  input wire logic serial_out_line,
  input wire logic serial_out_oe,
  input wire logic sclk_dev_oe,
  input wire logic sclk_wire
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic hold;
  // data may only move while the shift clock is low
  assign hold = sclk_wire && serial_out_oe;
  a_self_lead: assert property ($rose(serial_out_oe) && mode_strap == 2'b01 |-> !sclk_wire [*7])
    else $error("clock rose too soon");
  a_self_shift: assert property (hold && $past(hold) && mode_strap == 2'b01 |-> $stable(serial_out_line))
    else $error("self data moved");
  a_host_shift: assert property (hold && $past(hold) && mode_strap == 2'b00 |-> $stable(serial_out_line))
    else $error("host data moved");
  a_async_shift: assert property (hold && $past(hold) && mode_strap == 2'b10 |-> $stable(serial_out_line))
    else $error("async data moved");
  a_start_ready: assert property ($rose(serial_out_oe) |-> !$past(word_ready_n))
    else $error("start without word");
  a_idle_float: assert property (cs_n && !serial_out_oe && !sclk_dev_oe |=> !serial_out_oe && !sclk_dev_oe)
    else $error("driven while idle");
  a_self_float: assert property ($rose(cs_n) && mode_strap == 2'b01 |-> ##[0:16] !serial_out_oe && !sclk_dev_oe)
    else $error("self outputs stay driven");
  a_async_end: assert property ($rose(cs_n) && mode_strap == 2'b10 |-> ##[0:200] !serial_out_oe)
    else $error("async line stays driven");
  cover property ($rose(serial_out_oe) && mode_strap == 2'b00);
  cover property ($rose(serial_out_oe) && mode_strap == 2'b01);
  cover property ($rose(serial_out_oe) && mode_strap == 2'b10);
endmodule // adc_link_checker

// *** testbench/adc_serial_output_port_test.sv ***
// end-to-end bench: host and device ends on one link, host driven over apb
// assumes the hw/ package, interface and modules are compiled first
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
module adc_serial_output_port_test;
  logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, valid = 0, above = 0, below = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] word = 16'h0, lastw, expw;
  logic [15:0] exp_q[$];
  logic [1:0] sel;
  logic pready, pslverr, err, ready, cal_start;
  adc_port_pkg::mode_t mode;
  int mismatches = 0, checks_done = 0, seed = 9, n, k;
  adc_link_if link ();
  always #20 ref_clk = ~ref_clk;
  adc_port_device adc_port_device_inst (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .sample_word(word), .sample_above_ref(above), .sample_below_floor(below),
    .sample_valid(valid), .sample_ready(ready), .cal_start(cal_start), .cal_select(sel),
    .port_mode(mode), .link(link.device));
  adc_port_host adc_port_host_inst (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  adc_link_checker checker_inst (.ref_clk(ref_clk), .reset(reset), .cs_n(link.cs_n),
    .mode_strap(link.mode_strap), .word_ready_n(link.word_ready_n),
    .serial_out_line(link.serial_out_line), .serial_out_oe(link.serial_out_oe),
    .sclk_dev_oe(link.sclk_dev_oe), .sclk_wire(link.sclk_wire));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1 && c++ < 50);
    if (c > 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 0;
    repeat (6) @(posedge ref_clk);
    apb(0, 8'h10, 0);
    `CHK({err, rd}, 33'h100000000)
    for (int t = 0; t < 4; t++) begin
      apb(1, adc_port_pkg::REG_CMD, 32'(t << adc_port_pkg::CMD_TRIM_LSB | 2));
      n = 0;
      while (cal_start !== 1'b1 && n++ < 99) @(posedge ref_clk);
      `CHK({cal_start, sel}, {1'b1, 2'(t)})
      n = 0;
      do apb(0, adc_port_pkg::REG_STATUS, 0); while (rd[3] !== 1'b0 && n++ < 50);
      if (n > 50) mismatches++;
    end
    for (int i = 0; i < 10; i++) begin
      apb(1, adc_port_pkg::REG_CTRL, i % 3);
      if (i < 9) begin
        word <= $random(seed);
        above <= i / 3 == 1;
        below <= i / 3 > 0;
        valid <= 1;
        @(posedge ref_clk);
        valid <= 0;
        exp_q.push_back(i < 3 ? word : (i < 6 ? 16'hffff : 16'h0000));
      end else
        // a full buffer pops one word per five cycles
        repeat (400) @(posedge ref_clk);
      n = 0;
      while (link.word_ready_n !== 1'b0 && n++ < 99) @(posedge ref_clk);
      if (n > 99) mismatches++;
      apb(1, adc_port_pkg::REG_CMD, 1);
      // the device re-reads the strap only once back in idle, after the word update
      `CHK(mode, 2'(i % 3))
      if (i == 8) begin
        below <= 0;
        n = 0;
        while (link.serial_out_oe !== 1'b1 && n++ < 99) @(posedge ref_clk);
        if (n > 99) mismatches++;
        valid <= 1;
        k = 0;
        repeat (40) begin
          @(posedge ref_clk);
          if (ready === 1'b1) k++;
          if (ready === 1'b1) lastw = word;
          word <= $random(seed);
        end
        valid <= 0;
        `CHK(k, 32)
      end
      n = 0;
      do apb(0, adc_port_pkg::REG_STATUS, 0); while (rd[1] !== 1'b1 && n++ < 900);
      if (n > 900) mismatches++;
      apb(0, adc_port_pkg::REG_DATA, 0);
      expw = exp_q.pop_front();
      `CHK(rd[15:0], expw)
      if (i == 8) exp_q.push_back(lastw);
    end
    // asleep: start is refused and a new sample is not moved into the output word
    apb(1, adc_port_pkg::REG_CTRL, 32'h4);
    apb(1, adc_port_pkg::REG_CMD, 32'h1);
    apb(0, adc_port_pkg::REG_STATUS, 0);
    `CHK(rd[0], 1'b0)
    apb(0, adc_port_pkg::REG_CTRL, 0);
    `CHK(rd[2:0], 3'h4)
    valid <= 1;
    @(posedge ref_clk);
    valid <= 0;
    repeat (20) @(posedge ref_clk);
    `CHK(link.word_ready_n, 1'b1)
    end_sim();
  end
endmodule // adc_serial_output_port_test
